// ==== test/test_uis_top.sv ====
`timescale 1ns/1ps
module test_uis_top
  import uis_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic fifo_en = 1'b0, enh_en = 1'b0, tx_line, div_access, brk_seen;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, ev = 8'h00, reg_rdata, d, v;
  uis_fmt_s fmt;
  int error_cnt = 0, comparisons = 0;
  // status codes in service order
  logic [5:0] codes [9] = '{CODE_LINE, CODE_RXD, CODE_RTO, CODE_THE,
    CODE_MDM, CODE_FLOW, CODE_FLOW, CODE_CTRL, CODE_NONE};
  always #2.5 clk = ~clk;
  // raw line idles high, so low means break
  uis_top dut_u (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ev_line(ev[0]), .ev_rxd(ev[1]), .ev_rto(ev[2]),
    .ev_the(ev[3]), .ev_mdm(ev[4]), .ev_flow_stop(ev[5]),
    .ev_flow_resume(ev[6]), .ev_ctrl(ev[7]), .fifo_en, .enh_en,
    .tx_raw(1'b1), .tx_line, .fmt, .div_access);
  uis_peer peer_u (.clk, .tx_line, .brk_seen);
  task automatic chk(string n, logic [10:0] e, logic [10:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] w);
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, w};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [2:0] a, output logic [7:0] q);
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    q = reg_rdata;
  endtask
  task automatic pulse(logic [7:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 8'h00;
  endtask
  task automatic finish_test();
    $display("mismatches %0d of %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(ADDR_ISS, d);
    chk("status", 8'h01, d);
    rd(ADDR_LFC, d);
    chk("format", LFC_RESET, d);
    // all sources at once; pass 0 without fifo and enhanced mode
    for (int p = 0; p < 2; p++) begin
      {fifo_en, enh_en} <= {2{p[0]}};
      pulse(8'hbf);
      for (int i = 0; i < 9; i++) begin
        if (i == 7) pulse(8'h40);
        rd(ADDR_ISS, d);
        v = {{2{p[0]}}, ((p || i < 5) ? codes[i] : CODE_NONE)};
        chk("status", v, d);
      end
    end
    for (int i = 0; i < 8; i++) begin
      v = {1'b0, i[0], i[1], i[2], i[0], i[2], i[1:0]};
      wr(ADDR_LFC, v);
      repeat (12) @(posedge clk);
      rd(ADDR_LFC, d);
      chk("format", v, d);
      chk("fmt", {4'h5 + v[1:0], !v[2] ? 2'h2 : v[1:0] == 2'h0 ? 2'h3 : 2'h0,
        v[3], v[5], v[4], v[6], 1'b0}, fmt);
      chk("break", v[6], brk_seen);
    end
    wr(ADDR_LFC, 8'h80);
    repeat (2) @(posedge clk);
    chk("divisor", 11'h001, {10'h000, div_access});
    pulse(8'h01);
    rd(ADDR_ISS, d);
    chk("hidden", 8'h00, d);
    wr(ADDR_LFC, 8'h00);
    rd(ADDR_ISS, d);
    chk("status", {2'h3, CODE_LINE}, d);
    rd(ADDR_ISS, d);
    chk("status", {2'h3, CODE_NONE}, d);
    rd(3'h5, d);
    chk("unmapped", 8'h00, d);
    finish_test();
  end
endmodule

// ==== test/uis_checker.sv ====
`timescale 1ns/1ps
module uis_chk
  import uis_pkg::*;
(
  // watched top ports
  input wire logic       clk, rst, reg_rd, ev_line,
  input wire logic       fifo_en, enh_en, tx_line, div_access,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_rdata,
  input wire uis_fmt_s   fmt
);
  // status read with the general set visible
  logic st;
  always_ff @(posedge clk or posedge rst)
    if (rst) st <= 1'b0;
    else st <= reg_rd && reg_addr == ADDR_ISS && !div_access;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_FIFO: assert property (
    st |-> reg_rdata[7:6] == {2{$past(fifo_en)}}) else $error("fifo bits");
  AST_ENH: assert property (
    st && !$past(enh_en) |-> reg_rdata[5:4] == 2'h0) else $error("enh");
  AST_IDLE: assert property (
    st && reg_rdata[0] |-> reg_rdata[5:1] == 5'h00) else $error("idle");
  AST_LINE: assert property (
    st && !$past(st) && $past(ev_line, 3) |-> reg_rdata[5:0] == CODE_LINE)
    else $error("line code");
  AST_DENY: assert property (
    reg_rd && reg_addr == ADDR_ISS && div_access |=> reg_rdata == 8'h00)
    else $error("hidden read");
  AST_BRK: assert property (
    fmt.brk && $past(fmt.brk) |-> !tx_line) else $error("break");
  AST_LEN: assert property (
    !$past(rst) |-> fmt.data_bits inside {[4'h5:4'h8]}) else $error("len");
  AST_STOP: assert property (
    fmt.stop_halves[0] |-> fmt.data_bits == 4'h5) else $error("stop");
endmodule
bind uis_top uis_chk chk_u (.*);

// ==== test/uis_peer.sv ====
`timescale 1ns/1ps
// remote receiver: line low for eight clocks reads as break
module uis_peer (
  // line and verdict
  input  wire logic clk, tx_line,
  output logic      brk_seen
);
  logic [3:0] low_cnt;
  // saturating count so a long break stays flagged
  always_ff @(posedge clk) begin
    low_cnt <= tx_line ? 4'h0 : low_cnt + {3'h0, low_cnt != 4'h8};
    brk_seen <= low_cnt == 4'h8;
  end
endmodule

// ==== verilog/uis_pkg.sv ====
package uis_pkg;
  // register offsets on the plain register port
  localparam logic [2:0] ADDR_ISS = 3'h2;  // read: interrupt_source_status
  localparam logic [2:0] ADDR_LFC = 3'h3;  // read/write: line_format_control
  // values after reset
  localparam logic [7:0] LFC_RESET = 8'h00;
  localparam logic [5:0] CODE_NONE = 6'h01;
  // interrupt codes, status bits five down to zero
  localparam logic [5:0] CODE_LINE = 6'h06;
  localparam logic [5:0] CODE_RXD  = 6'h04;
  localparam logic [5:0] CODE_RTO  = 6'h0c;
  localparam logic [5:0] CODE_THE  = 6'h02;
  localparam logic [5:0] CODE_MDM  = 6'h00;
  localparam logic [5:0] CODE_FLOW = 6'h10;
  localparam logic [5:0] CODE_CTRL = 6'h20;
  // line control field positions
  localparam int LFC_DIV   = 7;
  localparam int LFC_BRK   = 6;
  localparam int LFC_FORCE = 5;
  localparam int LFC_EVEN  = 4;
  localparam int LFC_PEN   = 3;
  localparam int LFC_STOP  = 2;

  // pending source indices in priority order
  typedef enum logic [2:0] {
    UIS_SRC_LINE = 3'b000,
    UIS_SRC_RXD  = 3'b001,
    UIS_SRC_RTO  = 3'b010,
    UIS_SRC_THE  = 3'b011,
    UIS_SRC_MDM  = 3'b100,
    UIS_SRC_FLOW = 3'b101,
    UIS_SRC_CTRL = 3'b110,
    UIS_SRC_NONE = 3'b111
  } uis_src_e;

  // decoded character format
  typedef struct packed {
    logic [3:0] data_bits;   // 5..8
    logic [1:0] stop_halves; // stop length in half bit times
    logic       par_en;
    logic       par_force;
    logic       par_even;
    logic       brk;
    logic       div_access;
  } uis_fmt_s;
endpackage

// ==== verilog/uis_top.sv ====
`timescale 1ns/1ps
// Summary of operation
// - six priority levels, report only highest
// - status read clears only reported source
// - line status: priority 1, code 000110
// - receive data 000100, timeout 001100, priority 2
// - transmit empty 000010, modem 000000
// - flow stop or special char: 010000
// - flow line change: code 100000
// - bits 7-6 one while fifos enabled
// - bits 5-4 only with enhanced enable
// - flow-stop bit holds until resume char or enhanced off
// - bit 0 low when interrupt pending
// - bit 7 exposes divisor, hides general
// - bit 6 holds transmit line low
// - bit 3 enables parity generate/check
// - bit 4 selects odd or even
// - bit 5 forces constant parity bit
// - bits 1-0 set character length
// - length codes five through eight bits
// - bit 2 selects stop bit length
module uis_top
  import uis_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // event pulses from neighbouring blocks
  input  wire logic       ev_line,
  input  wire logic       ev_rxd,
  input  wire logic       ev_rto,
  input  wire logic       ev_the,
  input  wire logic       ev_mdm,
  input  wire logic       ev_flow_stop,
  input  wire logic       ev_flow_resume,
  input  wire logic       ev_ctrl,
  // mode inputs
  input  wire logic       fifo_en,
  input  wire logic       enh_en,
  // transmit line before and after break
  input  wire logic       tx_raw,
  output logic            tx_line,
  // format and access outputs
  output uis_fmt_s        fmt,
  output logic            div_access
);

  // control register and the views decoded from it
  logic [7:0] line_format_control;
  logic       div_open;   // divisor window open, general set hidden
  logic       brk_on;     // break requested by software
  logic [1:0] len_code;   // raw word length field
  logic       stop_long;  // longer stop selection
  uis_fmt_s   next_fmt;   // format view before its output register
  logic [7:0] next_rdata; // read data before its output register
  logic       next_tx;    // transmit level before its output register

  // register port strobes
  logic       iss_rd;     // status read on the port
  logic       ack;        // status read that may service a source

  // one sticky bit per source, highest level first
  logic       pend_line;
  logic       pend_rxd;
  logic       pend_rto;
  logic       pend_the;
  logic       pend_mdm;
  logic       pend_flow;
  logic       pend_ctrl;
  logic [6:0] pend;       // the same bits gathered for the encoder
  logic [6:0] ack_vec;    // the source that this read services

  // set and clear term of every source
  logic       line_set;
  logic       line_clr;
  logic       rxd_set;
  logic       rxd_clr;
  logic       rto_set;
  logic       rto_clr;
  logic       the_set;
  logic       the_clr;
  logic       mdm_set;
  logic       mdm_clr;
  logic       flow_set;
  logic       flow_clr;
  logic       ctrl_set;
  logic       ctrl_clr;

  // priority result
  uis_src_e   cur_src;
  logic [5:0] cur_code;
  logic [7:0] iss_value;

  // sticky update; an event in the clearing cycle wins, so a
  // source that fires again during its own service is not lost
  function automatic logic sticky(input logic cur,
                                  input logic set,
                                  input logic clr);
    return set | (cur & ~clr);
  endfunction

  // character length in data bits
  // shared by transmit and receive through one format view
  function automatic logic [3:0] length_of(input logic [1:0] code);
    logic [3:0] bits;
    case (code)
      2'h0:    bits = 4'h5;
      2'h1:    bits = 4'h6;
      2'h2:    bits = 4'h7;
      2'h3:    bits = 4'h8;
      default: bits = 4'h5;
    endcase
    return bits;
  endfunction

  // stop length in half bit times; two stops wrap to zero
  // because the field is only two bits wide
  function automatic logic [1:0] stop_of(input logic       long_stop,
                                         input logic [1:0] code);
    logic [1:0] halves;
    if (!long_stop) begin
      halves = 2'h2;
    end else if (code == 2'h0) begin
      halves = 2'h3;
    end else begin
      halves = 2'h0;
    end
    return halves;
  endfunction

  // decoded fields of the control register
  assign div_open  = line_format_control[LFC_DIV];
  assign brk_on    = line_format_control[LFC_BRK];
  assign len_code  = line_format_control[1:0];
  assign stop_long = line_format_control[LFC_STOP];

  // a status read behind the divisor window services nothing
  assign iss_rd = reg_rd && reg_addr == ADDR_ISS;
  assign ack    = iss_rd && !div_open;

  // the read services only the reported source
  // flow stop is left alone; only a resume character or leaving enhanced mode ends it
  always_comb begin
    ack_vec = 7'h00;
    if (ack) begin
      case (cur_src)
        UIS_SRC_LINE: ack_vec[UIS_SRC_LINE] = 1'b1;
        UIS_SRC_RXD:  ack_vec[UIS_SRC_RXD]  = 1'b1;
        UIS_SRC_RTO:  ack_vec[UIS_SRC_RTO]  = 1'b1;
        UIS_SRC_THE:  ack_vec[UIS_SRC_THE]  = 1'b1;
        UIS_SRC_MDM:  ack_vec[UIS_SRC_MDM]  = 1'b1;
        UIS_SRC_CTRL: ack_vec[UIS_SRC_CTRL] = 1'b1;
        default:      ack_vec = 7'h00;
      endcase
    end
  end

  // set terms; flow and control events count only when enhanced
  assign line_set = ev_line;
  assign rxd_set  = ev_rxd;
  assign rto_set  = ev_rto;
  assign the_set  = ev_the;
  assign mdm_set  = ev_mdm;
  assign flow_set = ev_flow_stop & enh_en;
  assign ctrl_set = ev_ctrl & enh_en;

  // clear terms; leaving enhanced mode drops both enhanced sources
  assign line_clr = ack_vec[UIS_SRC_LINE];
  assign rxd_clr  = ack_vec[UIS_SRC_RXD];
  assign rto_clr  = ack_vec[UIS_SRC_RTO];
  assign the_clr  = ack_vec[UIS_SRC_THE];
  assign mdm_clr  = ack_vec[UIS_SRC_MDM];
  assign flow_clr = ev_flow_resume | ~enh_en;
  assign ctrl_clr = ack_vec[UIS_SRC_CTRL] | ~enh_en;

  // sticky bits gathered in priority order for the encoder
  assign pend = {pend_ctrl, pend_flow, pend_mdm, pend_the,
                 pend_rto, pend_rxd, pend_line};

  // register writes; general set hidden while divisor access is open
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_format_control <= LFC_RESET;
    end else if (reg_wr && reg_addr == ADDR_LFC) begin
      line_format_control <= reg_wdata;
    end
  end

  // fixed priority, line status first; a fresh higher source
  // replaces the lower one before the next read
  always_comb begin
    if (pend[UIS_SRC_LINE]) begin
      cur_src = UIS_SRC_LINE;
    end else if (pend[UIS_SRC_RXD]) begin
      cur_src = UIS_SRC_RXD;
    end else if (pend[UIS_SRC_RTO]) begin
      cur_src = UIS_SRC_RTO;
    end else if (pend[UIS_SRC_THE]) begin
      cur_src = UIS_SRC_THE;
    end else if (pend[UIS_SRC_MDM]) begin
      cur_src = UIS_SRC_MDM;
    end else if (pend[UIS_SRC_FLOW]) begin
      cur_src = UIS_SRC_FLOW;
    end else if (pend[UIS_SRC_CTRL]) begin
      cur_src = UIS_SRC_CTRL;
    end else begin
      cur_src = UIS_SRC_NONE;
    end
  end

  // code for the reported source
  always_comb begin
    case (cur_src)
      UIS_SRC_LINE: cur_code = CODE_LINE;
      UIS_SRC_RXD:  cur_code = CODE_RXD;
      UIS_SRC_RTO:  cur_code = CODE_RTO;
      UIS_SRC_THE:  cur_code = CODE_THE;
      UIS_SRC_MDM:  cur_code = CODE_MDM;
      UIS_SRC_FLOW: cur_code = CODE_FLOW;
      UIS_SRC_CTRL: cur_code = CODE_CTRL;
      default:      cur_code = CODE_NONE;
    endcase
  end

  // status byte: fifo flags, enhanced bits, then the level code
  // bits 5-4 stay zero outside enhanced mode
  always_comb begin
    iss_value      = 8'h00;
    iss_value[7:6] = {2{fifo_en}};
    if (enh_en) begin
      iss_value[5:4] = cur_code[5:4];
    end else begin
      iss_value[5:4] = 2'h0;
    end
    iss_value[3:0] = cur_code[3:0];
  end

  // line status source, level one
  // serviced by the status read that reports it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_line <= 1'b0;
    end else begin
      pend_line <= sticky(pend_line, line_set, line_clr);
    end
  end

  // received data source, level two
  // ranks above the time-out that shares its level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_rxd <= 1'b0;
    end else begin
      pend_rxd <= sticky(pend_rxd, rxd_set, rxd_clr);
    end
  end

  // receive time-out source, level two
  // reported once the data source is serviced
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_rto <= 1'b0;
    end else begin
      pend_rto <= sticky(pend_rto, rto_set, rto_clr);
    end
  end

  // transmit holding empty source, level three
  // kept until the read that reports it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_the <= 1'b0;
    end else begin
      pend_the <= sticky(pend_the, the_set, the_clr);
    end
  end

  // modem status source, level four
  // its code is all zero, so bit 0 alone tells it apart
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_mdm <= 1'b0;
    end else begin
      pend_mdm <= sticky(pend_mdm, mdm_set, mdm_clr);
    end
  end

  // flow stop source, level five
  // reads never clear it; it holds until a resume character or enhanced mode is left
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_flow <= 1'b0;
    end else begin
      pend_flow <= sticky(pend_flow, flow_set, flow_clr);
    end
  end

  // flow line change source, level six
  // lowest level, so it waits behind every other source
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pend_ctrl <= 1'b0;
    end else begin
      pend_ctrl <= sticky(pend_ctrl, ctrl_set, ctrl_clr);
    end
  end

  // read data for the cycle after the strobe, zero otherwise
  // the status register reads zero while the divisor window is open
  always_comb begin
    next_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_ISS: next_rdata = div_open ? 8'h00 : iss_value;
        ADDR_LFC: next_rdata = line_format_control;
        default:  next_rdata = 8'h00;
      endcase
    end
  end

  // read data register, valid only in the cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // break forces the line low until software clears it; the raw
  // line passes one cycle late so the pin comes from a flip-flop
  always_comb begin
    next_tx = tx_raw;
    if (brk_on) begin
      next_tx = 1'b0;
    end
  end

  // transmit pin register; idles high through reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_line <= 1'b1;
    end else begin
      tx_line <= next_tx;
    end
  end

  // next format view; length and stop share one field decode
  // one view serves both shift registers, so they never disagree
  always_comb begin
    next_fmt             = '0;
    next_fmt.data_bits   = length_of(len_code);
    next_fmt.stop_halves = stop_of(stop_long, len_code);
    next_fmt.par_en      = line_format_control[LFC_PEN];
    next_fmt.par_force   = line_format_control[LFC_FORCE];
    next_fmt.par_even    = line_format_control[LFC_EVEN];
    next_fmt.brk         = brk_on;
    next_fmt.div_access  = div_open;
  end

  // format register for the shift registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fmt <= '0;
    end else begin
      fmt <= next_fmt;
    end
  end

  // divisor window flag for the baud and enhanced blocks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_access <= 1'b0;
    end else begin
      div_access <= div_open;
    end
  end

endmodule
